// ===== design/remote_control_pin_interface.sv
/*
 Pin-side logic of a remote control transceiver: status lines, straps,
 amplifier enables, indicator, acknowledgement flag, register slave.
 Assumes the radio core reports packets and radio state over AXI4-Lite.
*/
// Added by the designer: the register offsets and the AXI4-Lite register port.
// What this block does
// - Strap low makes lines 0-3 outputs
// - Strap high makes lines 4-7 inputs
// - Sleep input low stops all but the register slave and serial reply line
// - Toggle mode: activation inverts output
// - Momentary mode: output follows received packets
// - Reset pin low resets the block
// - Receive amp enable during reception
// - Transmit amp enable during transmission
// - Reply only when reply permit high
// - Pairing button high starts join
// - Long button hold asks factory restore
// - Indicator flash length shows role
// - Raise flag when confirm arrives
// - Serial reply and command lines
// - Resend captured inputs every 140 ms
// - Flag held 20 ms unless told
// - Toggle only when bit rises
// - Responding role ends after 760 ms
`timescale 1ns/1ns
`include "rc_cfg.svh"
module remote_control_pin_interface
	import rc_pkg::*;
#(
	parameter int MS_CYCLES = `RC_MS_NS / `RC_CLK_NS,
	parameter int FACTORY_MS = `RC_FACTORY_MS
)(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Register bus
	input  wire axil_req_t  bus_req,
	output axil_rsp_t       bus_rsp,
	// Status lines
	input  wire logic [7:0] remote_state_lines_in,
	output logic [7:0]      remote_state_lines_out,
	output logic [7:0]      remote_state_lines_oe,
	// Straps and control pins
	input  wire logic       low_group_direction,
	input  wire logic       high_group_direction,
	input  wire logic       sleep_request_n,
	input  wire logic       toggle_output_select,
	input  wire logic       reset_n,
	input  wire logic       confirm_reply_permit,
	input  wire logic       pairing_button,
	input  wire logic       serial_command_line,
	// Indicator and amplifier pins
	output logic            receive_amp_on,
	output logic            transmit_amp_on,
	output logic            activity_led,
	output logic            confirm_seen_flag,
	output logic            serial_reply_line
);
	// ============================================================
	// Input synchronisers
	logic [15:0] sync1_reg;
	logic [15:0] sync2_reg;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sync1_reg <= 16'h0000;
			sync2_reg <= 16'h0000;
		end
		else
		begin
			sync1_reg <= {serial_command_line, pairing_button, confirm_reply_permit,
				toggle_output_select, high_group_direction, low_group_direction,
				sleep_request_n, reset_n, remote_state_lines_in};
			sync2_reg <= sync1_reg;
		end
	end
	logic [7:0] lines_s;
	logic       rstn_s, awake, lo_dir, hi_dir, toggle_s, permit_s, pb_s, cmd_s;
	assign {cmd_s, pb_s, permit_s, toggle_s, hi_dir, lo_dir, awake, rstn_s, lines_s}
		= sync2_reg;
	logic int_rst;
	assign int_rst = rst | ~rstn_s;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (int_rst);
	// ============================================================
	// Millisecond tick
	logic [17:0] pre_reg;
	logic        tick;
	assign tick = (pre_reg == 18'(MS_CYCLES - 1));
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | tick)
			pre_reg <= 18'h00000;
		else
			pre_reg <= pre_reg + 18'h00001;
	end
	// ============================================================
	// Register slave
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		reg_idx = a[4:2];
	endfunction
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a[7:2] <= 6'h05);
	endfunction
	logic [1:0]  ctrl_reg;
	logic        serial_reg;
	logic        bvalid_reg, rvalid_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic        wr_fire, rd_fire;
	logic [2:0]  widx;
	logic [31:0] wd;
	assign wr_fire = bus_req.awvalid & bus_req.wvalid & ~bvalid_reg;
	assign rd_fire = bus_req.arvalid & ~rvalid_reg;
	assign widx = reg_idx(bus_req.awaddr);
	assign wd = bus_req.wdata;
	logic wr_ok;
	assign wr_ok = wr_fire & reg_hit(bus_req.awaddr);
	logic rx_evt, ack_evt, st_wr;
	assign rx_evt = wr_ok & (widx == 3'(`RC_RXPKT_OFS >> 2)) & awake
		& bus_req.wstrb[0];
	assign st_wr = wr_ok & (widx == 3'(`RC_STATUS_OFS >> 2)) & bus_req.wstrb[1];
	always_ff @(posedge ref_clk)
	begin
		if (int_rst)
		begin
			ctrl_reg   <= `RC_CTRL_RST;
			serial_reg <= `RC_SERIAL_RST;
		end
		else if (wr_ok & bus_req.wstrb[0])
		begin
			if (widx == 3'(`RC_CTRL_OFS >> 2))
				ctrl_reg <= wd[1:0];
			if (widx == 3'(`RC_SERIAL_OFS >> 2))
				serial_reg <= wd[0];
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (int_rst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'h0;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= reg_hit(bus_req.awaddr) ? 2'h0 : 2'h2;
		end
		else if (bus_req.bready)
			bvalid_reg <= 1'b0;
	end
	always_ff @(posedge ref_clk)
	begin
		if (int_rst)
		begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= 2'h0;
			rdata_reg  <= 32'h00000000;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= reg_hit(bus_req.araddr) ? 2'h0 : 2'h2;
			rdata_reg  <= rdata_next;
		end
		else if (bus_req.rready)
			rvalid_reg <= 1'b0;
	end
	assign bus_rsp.awready = wr_fire;
	assign bus_rsp.wready  = wr_fire;
	assign bus_rsp.bvalid  = bvalid_reg;
	assign bus_rsp.bresp   = bresp_reg;
	assign bus_rsp.arready = rd_fire;
	assign bus_rsp.rvalid  = rvalid_reg;
	assign bus_rsp.rdata   = rdata_reg;
	assign bus_rsp.rresp   = rresp_reg;
	// ============================================================
	// Transmit side: capture and resend while an input is high
	logic [7:0] in_mask, captured_reg;
	logic [7:0] tx_ms_reg;
	logic [1:0] final_reg;
	logic       any_high, any_prev_reg, iu_role, send;
	assign in_mask = lines_s & {{4{hi_dir}}, {4{lo_dir}}};
	assign any_high = |in_mask;
	assign iu_role = any_high | (final_reg != 2'h0);
	assign send = awake & ((any_high & ~any_prev_reg)
		| (iu_role & tick & (tx_ms_reg == 8'(`RC_RESEND_MS - 1))));
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
		begin
			tx_ms_reg    <= 8'h00;
			final_reg    <= 2'h0;
			any_prev_reg <= 1'b0;
			captured_reg <= 8'h00;
		end
		else
		begin
			any_prev_reg <= any_high;
			if (send)
			begin
				tx_ms_reg    <= 8'h00;
				captured_reg <= in_mask;
			end
			else if (iu_role & tick)
				tx_ms_reg <= tx_ms_reg + 8'h01;
			// Two trailing sends report all lines low
			if (any_high)
				final_reg <= 2'h2;
			else if (send)
				final_reg <= final_reg - 2'h1;
		end
	end
	// ============================================================
	// Receive side: responding role and status outputs
	logic [9:0] ru_ms_reg;
	logic       ru_role_reg;
	logic [7:0] out_reg, last_rx_reg;
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
		begin
			ru_role_reg <= 1'b0;
			ru_ms_reg   <= 10'h000;
		end
		else if (rx_evt)
		begin
			ru_role_reg <= 1'b1;
			ru_ms_reg   <= 10'h000;
		end
		else if (ru_role_reg & tick)
		begin
			if (ru_ms_reg == 10'(`RC_RU_HOLD_MS - 1))
				ru_role_reg <= 1'b0;
			else
				ru_ms_reg <= ru_ms_reg + 10'h001;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
		begin
			out_reg     <= 8'h00;
			last_rx_reg <= 8'h00;
		end
		else if (rx_evt)
		begin
			last_rx_reg <= wd[7:0];
			if (toggle_s)
				out_reg <= out_reg ^ (wd[7:0] & ~last_rx_reg);
			else
				out_reg <= wd[7:0];
		end
		else if (~ru_role_reg & ~toggle_s)
			out_reg <= 8'h00;
	end
	// Lines float while in reset, so a held reset pin never fights the load
	logic drive_ok;
	assign drive_ok = awake & ~int_rst;
	assign remote_state_lines_oe  = {{4{~hi_dir & drive_ok}}, {4{~lo_dir & drive_ok}}};
	assign remote_state_lines_out = out_reg;
	// ============================================================
	// Acknowledgement, pairing and reply requests
	logic [15:0] ack_ms_reg;
	logic        flag_reg, reply_reg, join_reg, factory_reg, txpend_reg, pb_prev_reg;
	logic [12:0] hold_reg;
	assign ack_evt = wr_ok & (widx == 3'(`RC_ACKPKT_OFS >> 2)) & iu_role
		& bus_req.wstrb[0];
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
		begin
			ack_ms_reg <= 16'h0000;
			flag_reg   <= 1'b0;
		end
		else if (ack_evt)
		begin
			ack_ms_reg <= (wd[15:0] == 16'h0000) ? 16'(`RC_ACK_DEF_MS) : wd[15:0];
			flag_reg   <= 1'b1;
		end
		else if (tick & flag_reg)
		begin
			ack_ms_reg <= ack_ms_reg - 16'h0001;
			if (ack_ms_reg == 16'h0001)
				flag_reg <= 1'b0;
		end
	end
	// Hardware sets win over software clears in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
		begin
			reply_reg   <= 1'b0;
			join_reg    <= 1'b0;
			factory_reg <= 1'b0;
			txpend_reg  <= 1'b0;
			pb_prev_reg <= 1'b0;
			hold_reg    <= 13'h0000;
		end
		else
		begin
			pb_prev_reg <= pb_s;
			if (rx_evt & permit_s)
				reply_reg <= 1'b1;
			else if (st_wr & wd[`RC_ST_REPLY])
				reply_reg <= 1'b0;
			if (pb_s & ~pb_prev_reg)
				join_reg <= 1'b1;
			else if (st_wr & wd[`RC_ST_JOIN])
				join_reg <= 1'b0;
			// Holding the button is taken as the restore sequence
			if (~pb_s)
				hold_reg <= 13'h0000;
			else if (tick & (hold_reg != 13'(FACTORY_MS)))
				hold_reg <= hold_reg + 13'h0001;
			if (pb_s & tick & (hold_reg == 13'(FACTORY_MS - 1)))
				factory_reg <= 1'b1;
			else if (st_wr & wd[`RC_ST_FACTORY])
				factory_reg <= 1'b0;
			if (send)
				txpend_reg <= 1'b1;
			else if (st_wr & wd[`RC_ST_TXPEND])
				txpend_reg <= 1'b0;
		end
	end
	// ============================================================
	// Role, indicator and pin drivers
	role_t      role;
	logic [9:0] led_ms_reg, lit_ms;
	always_comb
	begin
		if (~awake)
			role = ROLE_SLEEP;
		else if (iu_role)
			role = ROLE_IU;
		else if (ru_role_reg)
			role = ROLE_RU;
		else
			role = ROLE_IDLE;
		unique case (role)
			ROLE_SLEEP: lit_ms = 10'h000;
			ROLE_IU:    lit_ms = 10'(`RC_LED_IU_MS);
			ROLE_RU:    lit_ms = 10'(`RC_LED_RU_MS);
			ROLE_IDLE:  lit_ms = 10'(`RC_LED_IDLE_MS);
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (int_rst | ~awake)
			led_ms_reg <= 10'h000;
		else if (tick)
			led_ms_reg <= (led_ms_reg == 10'(`RC_LED_PER_MS - 1)) ? 10'h000
				: led_ms_reg + 10'h001;
	end
	always_ff @(posedge ref_clk)
	begin
		if (int_rst)
		begin
			activity_led      <= 1'b0;
			receive_amp_on    <= 1'b0;
			transmit_amp_on   <= 1'b0;
			confirm_seen_flag <= 1'b0;
			serial_reply_line <= 1'b1;
		end
		else
		begin
			activity_led      <= led_ms_reg < lit_ms;
			receive_amp_on    <= awake & ctrl_reg[`RC_CTRL_RX];
			transmit_amp_on   <= awake & ctrl_reg[`RC_CTRL_TX];
			confirm_seen_flag <= flag_reg;
			serial_reply_line <= serial_reg;
		end
	end
	always_comb
	begin
		rdata_next = 32'h00000000;
		unique case (reg_idx(bus_req.araddr))
			3'(`RC_CTRL_OFS >> 2):   rdata_next[1:0] = ctrl_reg;
			3'(`RC_STATUS_OFS >> 2): rdata_next[17:0] = {role, txpend_reg, reply_reg,
				factory_reg, join_reg, permit_s, toggle_s, hi_dir, lo_dir, lines_s};
			3'(`RC_TXINFO_OFS >> 2): rdata_next[7:0] = captured_reg;
			3'(`RC_SERIAL_OFS >> 2): rdata_next[1:0] = {cmd_s, serial_reg};
			default:                 rdata_next = 32'h00000000;
		endcase
		if (~reg_hit(bus_req.araddr))
			rdata_next = 32'h00000000;
	end
	// ============================================================
	// Checks
	property p_low_dir;
		lo_dir |-> remote_state_lines_oe[3:0] == 4'h0;
	endproperty
	a_low_dir: assert property (p_low_dir) else $error("low group driven as input");
	property p_high_dir;
		(~hi_dir & awake) |-> remote_state_lines_oe[7:4] == 4'hf;
	endproperty
	a_high_dir: assert property (p_high_dir) else $error("high group not driven");
	property p_sleep;
		~awake |-> remote_state_lines_oe == 8'h00
			##1 (~activity_led && ~receive_amp_on && ~transmit_amp_on);
	endproperty
	a_sleep: assert property (p_sleep) else $error("activity while asleep");
	property p_toggle;
		rx_evt && toggle_s |=> out_reg == ($past(out_reg) ^ ($past(wd[7:0])
			& ~$past(last_rx_reg)));
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle output wrong");
	property p_moment;
		rx_evt && ~toggle_s |=> out_reg == $past(wd[7:0])
			##1 (remote_state_lines_out == $past(wd[7:0], 2) || ~$past(awake));
	endproperty
	a_moment: assert property (p_moment) else $error("momentary output wrong");
	property p_reply;
		rx_evt && permit_s |=> reply_reg;
	endproperty
	a_reply: assert property (p_reply) else $error("reply request lost");
	property p_ack;
		ack_evt && awake |=> flag_reg ##1 confirm_seen_flag;
	endproperty
	a_ack: assert property (p_ack) else $error("confirm flag not raised");
	property p_capture;
		send |=> captured_reg == $past(in_mask) && txpend_reg;
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");
	property p_resend;
		iu_role && awake |-> tx_ms_reg < 8'(`RC_RESEND_MS);
	endproperty
	a_resend: assert property (p_resend) else $error("resend interval exceeded");
	property p_ru_end;
		ru_role_reg && ~rx_evt && tick && ru_ms_reg == 10'(`RC_RU_HOLD_MS - 1)
			|=> ~ru_role_reg;
	endproperty
	a_ru_end: assert property (p_ru_end) else $error("responding role overran");
endmodule

// ===== inc/rc_cfg.svh
/*
 Offsets, field positions, reset values and times of the remote control pin block.
 Assumes a 250 MHz clock; all times are counted in millisecond ticks.
*/
`ifndef RC_CFG_SVH
`define RC_CFG_SVH
// ============================================================
// Timing
`define RC_CLK_NS        4
`define RC_MS_NS         1000000
`define RC_RESEND_MS     140
`define RC_RU_HOLD_MS    760
`define RC_ACK_DEF_MS    20
`define RC_FACTORY_MS    5000
`define RC_LED_PER_MS    1000
`define RC_LED_IDLE_MS   20
`define RC_LED_RU_MS     200
`define RC_LED_IU_MS     600
// ============================================================
// Register offsets
`define RC_CTRL_OFS      8'h00
`define RC_RXPKT_OFS     8'h04
`define RC_ACKPKT_OFS    8'h08
`define RC_STATUS_OFS    8'h0c
`define RC_TXINFO_OFS    8'h10
`define RC_SERIAL_OFS    8'h14
// ============================================================
// Fields and reset values
`define RC_CTRL_RX       0
`define RC_CTRL_TX       1
`define RC_ST_JOIN       12
`define RC_ST_FACTORY    13
`define RC_ST_REPLY      14
`define RC_ST_TXPEND     15
`define RC_CTRL_RST      2'h0
`define RC_SERIAL_RST    1'h1
`endif

// ===== inc/rc_pkg.sv
/*
 Types of the remote control pin block: bus carriers and role codes.
 Assumes the AXI4-Lite master needs no protection bits.
*/
package rc_pkg;
	typedef struct packed {
		logic       awvalid;
		logic [7:0] awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		logic [7:0] araddr;
		logic       rready;
	} axil_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;
	typedef enum logic [1:0] {
		ROLE_IDLE  = 2'b00,
		ROLE_RU    = 2'b01,
		ROLE_IU    = 2'b10,
		ROLE_SLEEP = 2'b11
	} role_t;
endpackage

// ===== test/pin_partner.sv
/*
 Pin-side partner: contacts on the status lines and strap levels.
 Assumes the bench chooses the press and strap levels.
*/
`timescale 1ns/1ns
module pin_partner (
	// Design side
	input  wire logic [7:0] line_oe,
	input  wire logic [7:0] line_out,
	// Bench side
	input  wire logic [7:0] press,
	input  wire logic [1:0] strap_set,
	// Pins
	output logic [7:0]      line_pin,
	output logic [1:0]      strap_pin
);
	// =====
	// Levels
	// Straps are always driven, never left floating
	assign strap_pin = strap_set;
	// A press only reaches a line that the block does not drive
	assign line_pin = (line_oe & line_out) | (~line_oe & press);
endmodule

// ===== test/remote_control_pin_interface_tb.sv
/*
 Self-checking bench of the remote control pin block.
 Assumes a 10-cycle millisecond tick and a 5 ms factory hold.
*/
`timescale 1ns/1ns
`include "rc_cfg.svh"
module remote_control_pin_interface_tb;
	import rc_pkg::*;
	localparam int MS = 10;
	localparam int FMS = 5;
	logic        ref_clk = 0;
	logic        rst = 1;
	axil_req_t   q = '0;
	axil_rsp_t   r;
	logic [7:0]  pin, out, oe;
	logic [7:0]  press = 0;
	logic [1:0]  strap = 2'b10;
	logic [1:0]  sp;
	logic        sleep_n = 1, tog = 0, reset_n = 1, permit = 0, pb = 0, cmd = 0;
	logic        rx_amp, tx_amp, led, flag, reply;
	logic [1:0]  rsp;
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #2 ref_clk = ~ref_clk;
	// =====
	// Block and pins
	remote_control_pin_interface #(.MS_CYCLES(MS), .FACTORY_MS(FMS)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .bus_req(q), .bus_rsp(r),
		.remote_state_lines_in(pin), .remote_state_lines_out(out),
		.remote_state_lines_oe(oe), .low_group_direction(sp[0]),
		.high_group_direction(sp[1]), .sleep_request_n(sleep_n),
		.toggle_output_select(tog), .reset_n(reset_n),
		.confirm_reply_permit(permit), .pairing_button(pb),
		.serial_command_line(cmd), .receive_amp_on(rx_amp),
		.transmit_amp_on(tx_amp), .activity_led(led),
		.confirm_seen_flag(flag), .serial_reply_line(reply));
	pin_partner i_pins (.line_oe(oe), .line_out(out), .press(press),
		.strap_set(strap), .line_pin(pin), .strap_pin(sp));
	// =====
	// Helpers
	task report_and_stop;
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A hang counts as a mismatch
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		q.awaddr <= a;
		q.wdata <= d;
		q.wstrb <= 4'hf;
		q.awvalid <= 1'b1;
		q.wvalid <= 1'b1;
		q.bready <= 1'b1;
		do @(posedge ref_clk); while (r.awready !== 1'b1);
		q.awvalid <= 1'b0;
		q.wvalid <= 1'b0;
		do @(posedge ref_clk); while (r.bvalid !== 1'b1);
		rsp = r.bresp;
		q.bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		q.araddr <= a;
		q.arvalid <= 1'b1;
		q.rready <= 1'b1;
		do @(posedge ref_clk); while (r.arready !== 1'b1);
		q.arvalid <= 1'b0;
		do @(posedge ref_clk); while (r.rvalid !== 1'b1);
		d = r.rdata;
		rsp = r.rresp;
		q.rready <= 1'b0;
	endtask
	// =====
	// Scenarios
	task t_dir;
		chk(oe, 8'h0f);
		@(posedge ref_clk);
		strap <= 2'b01;
		wt(4);
		chk(oe, 8'hf0);
		@(posedge ref_clk);
		strap <= 2'b10;
		wt(4);
	endtask
	task t_led;
		int n;
		n = 0;
		repeat (1000 * MS)
		begin
			wt(1);
			n += (led === 1'b1);
		end
		chk(n >= 19 * MS && n <= 21 * MS, 1);
	endtask
	task t_amp;
		logic [31:0] d;
		wr(`RC_CTRL_OFS, 32'h1);
		wt(2);
		chk({tx_amp, rx_amp}, 2'b01);
		wr(`RC_CTRL_OFS, 32'h2);
		wt(2);
		chk({tx_amp, rx_amp}, 2'b10);
		rd(`RC_CTRL_OFS, d);
		chk(d, 32'h2);
	endtask
	task t_mom;
		logic [31:0] d;
		wr(`RC_RXPKT_OFS, 32'h5);
		wt(1);
		chk(pin[3:0], 4'h5);
		rd(`RC_STATUS_OFS, d);
		chk(d[17:16], ROLE_RU);
		// Outputs must outlive the gap between resends
		wt(750 * MS);
		chk(pin[3:0], 4'h5);
		wt(20 * MS);
		chk(pin[3:0], 4'h0);
	endtask
	task t_tog;
		logic [3:0] rx [6] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h3};
		logic [3:0] ex [6] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h0, 4'h2};
		@(posedge ref_clk);
		tog <= 1'b1;
		wt(4);
		for (int i = 0; i < 6; i++)
		begin
			wr(`RC_RXPKT_OFS, {28'h0, rx[i]});
			wt(1);
			chk(pin[3:0], ex[i]);
		end
		@(posedge ref_clk);
		tog <= 1'b0;
		wt(4);
	endtask
	task t_reply;
		logic [31:0] d;
		@(posedge ref_clk);
		permit <= 1'b1;
		wt(4);
		wr(`RC_RXPKT_OFS, 32'h0);
		rd(`RC_STATUS_OFS, d);
		chk(d[`RC_ST_REPLY], 1);
		wr(`RC_STATUS_OFS, 32'h1 << `RC_ST_REPLY);
		@(posedge ref_clk);
		permit <= 1'b0;
		wt(4);
		wr(`RC_RXPKT_OFS, 32'h0);
		rd(`RC_STATUS_OFS, d);
		chk(d[`RC_ST_REPLY], 0);
	endtask
	task t_tx;
		logic [31:0] d;
		int n;
		@(posedge ref_clk);
		press <= 8'h10;
		wt(5);
		rd(`RC_TXINFO_OFS, d);
		chk(d[7:0], 8'h10);
		wr(`RC_STATUS_OFS, 32'h1 << `RC_ST_TXPEND);
		rd(`RC_STATUS_OFS, d);
		chk(d[`RC_ST_TXPEND], 0);
		wt(145 * MS);
		rd(`RC_STATUS_OFS, d);
		chk(d[`RC_ST_TXPEND], 1);
		// Default length first, then a length carried by the confirm
		for (int k = 0; k < 2; k++)
		begin
			wr(`RC_ACKPKT_OFS, (k == 0) ? 32'h0 : 32'h3);
			#1;
			n = 0;
			while (flag === 1'b1 && n < 30 * MS)
			begin
				wt(1);
				n++;
			end
			if (k == 0)
				chk(n >= 19 * MS && n <= 21 * MS, 1);
			else
				chk(n >= 2 * MS && n <= 4 * MS, 1);
		end
		@(posedge ref_clk);
		press <= 8'h00;
		wt(4);
	endtask
	task t_pair;
		logic [31:0] d;
		@(posedge ref_clk);
		pb <= 1'b1;
		wt(4);
		rd(`RC_STATUS_OFS, d);
		chk(d[13:12], 2'b01);
		wt((FMS + 2) * MS);
		rd(`RC_STATUS_OFS, d);
		chk(d[`RC_ST_FACTORY], 1);
		@(posedge ref_clk);
		pb <= 1'b0;
	endtask
	task t_serial;
		logic [31:0] d;
		wr(`RC_SERIAL_OFS, 32'h0);
		wt(2);
		chk(reply, 0);
		@(posedge ref_clk);
		cmd <= 1'b1;
		wt(4);
		rd(`RC_SERIAL_OFS, d);
		chk(d[1:0], 2'b10);
		wr(8'h40, 32'h1);
		chk(rsp, 2'h2);
		rd(8'h40, d);
		chk(rsp, 2'h2);
		chk(d, 32'h0);
	endtask
	task t_sleep;
		logic [31:0] d;
		wr(`RC_CTRL_OFS, 32'h3);
		@(posedge ref_clk);
		sleep_n <= 1'b0;
		wt(4);
		chk({tx_amp, rx_amp, led}, 3'b000);
		rd(`RC_STATUS_OFS, d);
		chk(d[17:16], ROLE_SLEEP);
		@(posedge ref_clk);
		sleep_n <= 1'b1;
		wt(4);
	endtask
	task t_rstpin;
		wr(`RC_RXPKT_OFS, 32'hf);
		wt(1);
		chk(pin[3:0], 4'hf);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		wt(4);
		chk({out, oe, reply}, 17'h1);
		@(posedge ref_clk);
		reset_n <= 1'b1;
		wt(4);
		chk(oe, 8'h0f);
	endtask
	// =====
	// Main sequence
	initial
	begin
		wt(1);
		chk({out, oe, reply}, 17'h1);
		@(posedge ref_clk);
		rst <= 1'b0;
		wt(4);
		t_dir();
		t_led();
		t_amp();
		t_mom();
		t_tog();
		t_reply();
		t_tx();
		t_pair();
		t_serial();
		t_sleep();
		t_rstpin();
		report_and_stop();
	end
endmodule
